//--- verilog/sf_defines.svh
// Opcodes, status field positions, reset values and phase lengths
// for the serial flash command front end. Included by bare name.
`ifndef SF_DEFINES_SVH
`define SF_DEFINES_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define CMD_WR_EN       8'h06
`define CMD_WR_DIS      8'h04
`define CMD_ST_RD       8'h05
`define CMD_ST_WR       8'h01
`define CMD_RD          8'h03
`define CMD_FAST_RD     8'h0B
`define CMD_DUAL_RD     8'h3B
`define CMD_SECT_ERASE  8'h20
`define CMD_BLK_ERASE_A 8'h52
`define CMD_BLK_ERASE_B 8'hD8
`define CMD_CHIP_ERASE_A 8'h60
`define CMD_CHIP_ERASE_B 8'hC7
`define CMD_PAGE_PROG   8'h02
`define CMD_PWR_DOWN    8'hB9
`define CMD_RELEASE     8'hAB
`define CMD_ID_RD       8'h9F
`define CMD_MAKER_DEV   8'h90
`define CMD_SEC_RD      8'h2B
`define CMD_SEC_WR      8'h2F

// ----------------------------------------------------------------
// Status and security fields, reset values
// ----------------------------------------------------------------
`define ST_BUSY_BIT     0
`define ST_LATCH_BIT    1
`define ST_BP_LSB       2
`define SEC_FACTORY_BIT 0
`define SEC_LOCK_BIT    1
`define BP_RST          4'h0

// ----------------------------------------------------------------
// Frame lengths in bytes, opcode included, and the block count
// ----------------------------------------------------------------
`define LEN_ONE         4'h1
`define LEN_STATUS_WR   4'h2
`define LEN_ADDR        4'h4
`define LEN_DUMMY       4'h5
`define NUM_BLOCKS      8'd128

`endif

//--- verilog/sf_pkg.sv
// Types shared by the serial flash command front end.
// Assumes nothing beyond a SystemVerilog compiler.
package sf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACT  = 3'b010,
    ST_REJ  = 3'b100
  } link_state_e;

  typedef enum logic [1:0] {
    JOB_SECTOR = 2'h0,
    JOB_BLOCK  = 2'h1,
    JOB_CHIP   = 2'h2,
    JOB_PAGE   = 2'h3
  } job_e;

  typedef struct packed {
    job_e        kind;
    logic [22:0] addr;
  } job_req_s;

  typedef struct packed {
    logic [7:0] col;
    logic [7:0] data;
  } page_byte_s;

endpackage

//--- verilog/sf_cmd_if.sv
// Serial flash command front end: decodes the serial link, keeps
// status, drives the array back end. Assumes a back end that runs the
// program/erase algorithm and answers array reads within 3 cycles.
//
// What this block does
// - Accepts clock idle low or high
// - 06 sets, 04 clears write enable latch
// - 05 reads status, 01 writes status
// - 03, 0B, 3B read array after address
// - 20 erases sector, 52/D8 erase block
// - 60/C7 erase all, 02 programs page
// - B9 powers down, AB releases, gives signature
// - 9F returns maker then two-byte device code
// - 90 returns maker then device byte
// - 2B reads, 2F writes security register
// - 2048 sectors of 4 Kbytes, each erasable
// - 128 blocks of 64 Kbytes, each erasable
// - Program one byte up to 256-byte page
// - Dual read drives both data lines
// - Busy bit set while program or erase
// - Back end runs and verifies the operation
// - Only selected access; standby when idle
// - Four protect bits fence program and erase
// - 512-bit secured identifier area
// - Reads run on through all addresses
// - Sample on rising, shift on falling
// - Unknown opcode: silent until next select
// - Write-type commands end on byte boundary
// - Latch cleared at reset, status write and job completion
`timescale 1ns/1ns
`include "sf_defines.svh"

module sf_cmd_if #(
  parameter logic [7:0] MFR_ID = 8'hA5,  // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5A01,  // Arbitrary value
  parameter logic [7:0] MAKER_DEV_ID = 8'h01,  // Arbitrary value
  parameter logic [7:0] SIG_ID = 8'h11,  // Arbitrary value
  parameter logic [511:0] UNIQUE_ID = {64{8'h3C}},  // Arbitrary
  parameter logic FACTORY_LOCK = 1'b1,
  parameter logic [7:0] AREA_IN_OP = 8'hE1,
  parameter logic [7:0] AREA_OUT_OP = 8'hE2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dual_line_zero_i,
  output logic dual_line_zero_o,
  output logic dual_line_zero_oe_n,
  output logic dual_line_one_o,
  output logic dual_line_one_oe_n,
  output logic [22:0] arr_addr,
  input wire logic [7:0] arr_rdata,
  output logic job_start,
  output sf_pkg::job_req_s job,
  input wire logic job_done,
  output logic pg_wr,
  output sf_pkg::page_byte_s pg_byte,
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic [3:0] block_protect_field,
  output logic deep_power_down,
  output logic standby
);
  import sf_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_std(input logic [7:0] op);
    case (op)
      `CMD_WR_EN, `CMD_WR_DIS, `CMD_ST_RD, `CMD_ST_WR, `CMD_RD,
      `CMD_FAST_RD, `CMD_DUAL_RD, `CMD_SECT_ERASE, `CMD_BLK_ERASE_A,
      `CMD_BLK_ERASE_B, `CMD_CHIP_ERASE_A, `CMD_CHIP_ERASE_B,
      `CMD_PAGE_PROG, `CMD_PWR_DOWN, `CMD_RELEASE, `CMD_ID_RD,
      `CMD_MAKER_DEV, `CMD_SEC_RD, `CMD_SEC_WR: is_std = 1'b1;
      default: is_std = 1'b0;
    endcase
  endfunction

  if (AREA_IN_OP == AREA_OUT_OP || is_std(AREA_IN_OP) ||
      is_std(AREA_OUT_OP)) begin : g_bad_op
    $error("secured area opcodes collide");
  end

  // Power-down and busy narrow what is heard
  function automatic logic op_ok(input logic [7:0] op,
                                 input logic pd, input logic busy);
    if (pd)
      op_ok = (op == `CMD_RELEASE);
    else if (busy)
      op_ok = (op == `CMD_ST_RD) || (op == `CMD_SEC_RD);
    else
      op_ok = is_std(op) || op == AREA_IN_OP || op == AREA_OUT_OP;
  endfunction

  // Byte index at which data out begins; zero means no data out
  function automatic logic [3:0] out_start(input logic [7:0] op);
    case (op)
      `CMD_ST_RD, `CMD_SEC_RD, `CMD_ID_RD: out_start = `LEN_ONE;
      `CMD_RD, `CMD_RELEASE, `CMD_MAKER_DEV: out_start = `LEN_ADDR;
      `CMD_FAST_RD, `CMD_DUAL_RD: out_start = `LEN_DUMMY;
      default: out_start = 4'h0;
    endcase
  endfunction

  function automatic logic is_prot(input logic [3:0] bp,
                                   input logic [6:0] blk);
    logic [7:0] lim;
    lim = 8'h00;
    case (bp)
      4'h0: is_prot = 1'b0;
      4'h7, 4'h8, 4'hF: is_prot = 1'b1;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
        lim = `NUM_BLOCKS - (8'd1 << bp[2:0]);
        is_prot = {1'b0, blk} >= lim;
      end
      default: begin
        lim = `NUM_BLOCKS - (8'd1 << (4'hF - bp));
        is_prot = {1'b0, blk} < lim;
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------------------------------
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] d0_s;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      d0_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[1:0], cs_n};
      d0_s <= {d0_s[0], dual_line_zero_i};
    end
  end

  // Only edges seen while selected count, so either idle level works
  wire rise = sclk_s[1] & ~sclk_s[2];
  wire fall = ~sclk_s[1] & sclk_s[2];
  wire desel = cs_s[1];
  wire cs_fall = ~cs_s[1] & cs_s[2];
  wire cs_rise = cs_s[1] & ~cs_s[2];

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  link_state_e st_q;
  logic [7:0] shift_q;
  logic [7:0] op_q;
  logic [2:0] bit_q;
  logic [3:0] byte_q;
  logic [22:0] addr_q;
  logic [3:0] bp_new_q;
  logic [7:0] pcnt_q;
  logic busy_q;
  logic latch_q;
  logic [3:0] bp_q;
  logic pdown_q;
  logic area_q;
  logic lock_q;

  wire [7:0] in_byte = {shift_q[6:0], d0_s[1]};
  wire byte_end = (st_q == ST_ACT) && rise && (bit_q == 3'h7);
  wire has_addr = out_start(op_q) == `LEN_ADDR ||
                  out_start(op_q) == `LEN_DUMMY ||
                  op_q == `CMD_SECT_ERASE || op_q == `CMD_BLK_ERASE_A ||
                  op_q == `CMD_BLK_ERASE_B || op_q == `CMD_PAGE_PROG;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
    end else if (desel) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (cs_fall) st_q <= ST_ACT;
        ST_ACT: if (byte_end && byte_q == 4'h0 &&
                    !op_ok(in_byte, pdown_q, busy_q)) st_q <= ST_REJ;
        ST_REJ: st_q <= ST_REJ;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      byte_q <= 4'h0;
    end else if (cs_fall) begin
      bit_q <= 3'h0;
      byte_q <= 4'h0;
    end else if (st_q == ST_ACT && rise) begin
      shift_q <= in_byte;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7 && byte_q != 4'hF) byte_q <= byte_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_q <= 8'h00;
      addr_q <= 23'h0;
      bp_new_q <= `BP_RST;
    end else if (byte_end) begin
      if (byte_q == 4'h0) op_q <= in_byte;
      if (byte_q >= 4'h1 && byte_q <= 4'h3 && has_addr)
        addr_q <= {addr_q[14:0], in_byte};
      if (byte_q == 4'h1 && op_q == `CMD_ST_WR)
        bp_new_q <= in_byte[`ST_BP_LSB +: 4];
    end
  end

  // Page data streams to the back end buffer; column wraps in page
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pcnt_q <= 8'h00;
      pg_wr <= 1'b0;
      pg_byte <= '0;
    end else begin
      pg_wr <= 1'b0;
      if (cs_fall) begin
        pcnt_q <= 8'h00;
      end else if (byte_end && op_q == `CMD_PAGE_PROG &&
                   byte_q >= `LEN_ADDR) begin
        pg_wr <= 1'b1;
        pg_byte.col <= addr_q[7:0] + pcnt_q;
        pg_byte.data <= in_byte;
        pcnt_q <= pcnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Execution at deselect
  // ----------------------------------------------------------------
  // Write-type commands act only when select rose on a byte boundary
  wire exec = cs_rise && st_q == ST_ACT && bit_q == 3'h0;
  wire prot = is_prot(bp_q, addr_q[22:16]);
  wire one = byte_q == `LEN_ONE;
  wire erase_blk = op_q == `CMD_BLK_ERASE_A || op_q == `CMD_BLK_ERASE_B;
  wire erase_all = op_q == `CMD_CHIP_ERASE_A ||
                   op_q == `CMD_CHIP_ERASE_B;

  logic go;
  job_req_s go_job;

  always_comb begin
    go = 1'b0;
    go_job.kind = JOB_PAGE;
    go_job.addr = addr_q;
    if (exec && latch_q) begin
      if (op_q == `CMD_SECT_ERASE && byte_q == `LEN_ADDR && !prot) begin
        go = 1'b1;
        go_job.kind = JOB_SECTOR;
        go_job.addr = {addr_q[22:12], 12'h000};
      end else if (erase_blk && byte_q == `LEN_ADDR && !prot) begin
        go = 1'b1;
        go_job.kind = JOB_BLOCK;
        go_job.addr = {addr_q[22:16], 16'h0000};
      end else if (erase_all && one && bp_q == 4'h0) begin
        go = 1'b1;
        go_job.kind = JOB_CHIP;
        go_job.addr = 23'h0;
      end else if (op_q == `CMD_PAGE_PROG && byte_q > `LEN_ADDR &&
                   !prot) begin
        go = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      job_start <= 1'b0;
      job <= '0;
      busy_q <= 1'b0;
    end else begin
      job_start <= go;
      if (go) job <= go_job;
      if (go) busy_q <= 1'b1;
      else if (job_done) busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch_q <= 1'b0;
      bp_q <= `BP_RST;
    end else if (exec && op_q == `CMD_WR_EN && one) begin
      latch_q <= 1'b1;
    end else if (exec && op_q == `CMD_WR_DIS && one) begin
      latch_q <= 1'b0;
    end else if (exec && op_q == `CMD_ST_WR &&
                 byte_q == `LEN_STATUS_WR && latch_q) begin
      bp_q <= bp_new_q;
      latch_q <= 1'b0;
    end else if (busy_q && job_done) begin
      latch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pdown_q <= 1'b0;
      area_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      if (exec && op_q == `CMD_PWR_DOWN && one) pdown_q <= 1'b1;
      // Release acts whether or not the signature was read out
      if (cs_rise && st_q == ST_ACT && op_q == `CMD_RELEASE)
        pdown_q <= 1'b0;
      if (exec && op_q == AREA_IN_OP && one) area_q <= 1'b1;
      if (exec && op_q == AREA_OUT_OP && one) area_q <= 1'b0;
      if (exec && op_q == `CMD_SEC_WR && one && latch_q)
        lock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data out
  // ----------------------------------------------------------------
  logic [7:0] tx_q;
  logic [2:0] ocnt_q;
  logic [1:0] oidx_q;
  logic drive_q;
  logic [22:0] rd_addr_q;
  logic [7:0] src;
  logic [7:0] status;
  logic [7:0] secur;
  logic [511:0] uid_sh;

  wire dual = op_q == `CMD_DUAL_RD;
  wire is_read = op_q == `CMD_RD || op_q == `CMD_FAST_RD || dual;
  wire out_phase = st_q == ST_ACT && !desel && fall &&
                   out_start(op_q) != 4'h0 && byte_q >= out_start(op_q);
  wire out_load = out_phase && ocnt_q == 3'h0;
  // Plain read needs the address as its last byte lands
  wire load_now = byte_end && op_q == `CMD_RD && byte_q == 4'h3;
  wire load_dummy = byte_end && byte_q == 4'h4 &&
                    (op_q == `CMD_FAST_RD || dual);

  always_comb begin
    status = 8'h00;
    status[`ST_BUSY_BIT] = busy_q;
    status[`ST_LATCH_BIT] = latch_q;
    status[`ST_BP_LSB +: 4] = bp_q;
    secur = 8'h00;
    secur[`SEC_FACTORY_BIT] = FACTORY_LOCK;
    secur[`SEC_LOCK_BIT] = lock_q;
    uid_sh = UNIQUE_ID >> {rd_addr_q[5:0], 3'b000};
    case (op_q)
      `CMD_ST_RD: src = status;
      `CMD_SEC_RD: src = secur;
      `CMD_ID_RD: src = (oidx_q == 2'h0) ? MFR_ID :
                        (oidx_q == 2'h1) ? DEV_ID[15:8] :
                        DEV_ID[7:0];
      `CMD_MAKER_DEV: src = oidx_q[0] ? MAKER_DEV_ID : MFR_ID;
      `CMD_RELEASE: src = SIG_ID;
      default: src = area_q ? uid_sh[7:0] : arr_rdata;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_addr_q <= 23'h0;
    end else if (load_now) begin
      rd_addr_q <= {addr_q[14:0], in_byte};
    end else if (load_dummy) begin
      rd_addr_q <= addr_q;
    end else if (out_load && is_read) begin
      rd_addr_q <= rd_addr_q + 23'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_q <= 8'h00;
      ocnt_q <= 3'h0;
      oidx_q <= 2'h0;
      drive_q <= 1'b0;
    end else if (desel || st_q != ST_ACT) begin
      drive_q <= 1'b0;
      ocnt_q <= 3'h0;
      oidx_q <= 2'h0;
    end else if (out_phase) begin
      drive_q <= 1'b1;
      ocnt_q <= ocnt_q + (dual ? 3'h2 : 3'h1);
      if (out_load) begin
        tx_q <= src;
        if (oidx_q != 2'h3) oidx_q <= oidx_q + 2'h1;
      end else begin
        tx_q <= dual ? {tx_q[5:0], 2'b00} : {tx_q[6:0], 1'b0};
      end
    end
  end

  assign arr_addr = rd_addr_q;
  assign dual_line_one_o = tx_q[7];
  assign dual_line_zero_o = tx_q[6];
  assign dual_line_one_oe_n = ~drive_q;
  assign dual_line_zero_oe_n = ~(drive_q & dual);
  assign write_in_progress = busy_q;
  assign write_enable_latch = latch_q;
  assign block_protect_field = bp_q;
  assign deep_power_down = pdown_q;
  assign standby = desel & ~busy_q;

endmodule

//--- dv/sf_host_model.sv
// Host serial controller model for the flash command front end.
// Assumes the bench clk_sys at 100 MHz; link period is 8 clocks.
`timescale 1ns/1ns
module sf_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic line_zero,
  input wire logic line_one
);
  logic cpol = 1'b0;
  logic [7:0] rx[$];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ----
  // One frame: nb header bits, then nrd bytes read back
  // ----
  task automatic frame(input logic [63:0] hdr, input int nb,
                       input int nrd, input bit dual);
    logic [7:0] b;
    rx.delete();
    @(negedge clk_sys);
    sclk = cpol;
    cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = nb - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = hdr[i];
      repeat (4) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
    for (int k = 0; k < nrd; k++) begin
      for (int j = 0; j < (dual ? 4 : 8); j++) begin
        sclk = 1'b0;
        // Line zero is released in dual read, so it must not hold
        if (dual)
          mosi = ~mosi;
        repeat (4) @(negedge clk_sys);
        sclk = 1'b1;
        b = dual ? {b[5:0], line_one, line_zero} : {b[6:0], line_one};
        repeat (4) @(negedge clk_sys);
      end
      rx.push_back(b);
    end
    sclk = cpol;
    repeat (4) @(negedge clk_sys);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (6) @(negedge clk_sys);
  endtask
endmodule

//--- dv/sf_cmd_if_props.sv
// Port assertions for the flash command front end.
// Bound into every sf_cmd_if; one clock domain, async reset nrst.
`timescale 1ns/1ns
module sf_cmd_if_props
  import sf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic dual_line_zero_oe_n,
  input wire logic dual_line_one_oe_n,
  input wire logic job_start,
  input wire sf_pkg::job_req_s job,
  input wire logic job_done,
  input wire logic pg_wr,
  input wire logic write_in_progress,
  input wire logic write_enable_latch,
  input wire logic [3:0] block_protect_field,
  input wire logic deep_power_down,
  input wire logic standby
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_oe_deselect: assert property (cs_n [*5] |-> dual_line_one_oe_n)
    else $error("line one driven while deselected");
  a_dual_pair: assert property (!dual_line_zero_oe_n
    |-> !dual_line_one_oe_n) else $error("line zero driven alone");
  a_standby_idle: assert property ((cs_n [*4] ##0 !write_in_progress
    && !job_start) |-> standby) else $error("standby missing");
  a_active_sel: assert property (!cs_n [*4] |-> !standby)
    else $error("standby while selected");
  a_wip_rise: assert property (job_start |=> write_in_progress)
    else $error("busy not set after job start");
  a_wip_hold: assert property (write_in_progress && !job_done
    |=> write_in_progress) else $error("busy dropped early");
  a_done_clears: assert property (job_done && write_in_progress
    |=> !write_in_progress && !write_enable_latch)
    else $error("busy or latch kept after done");
  a_start_once: assert property (job_start |=> !job_start [*8])
    else $error("job start not a single pulse");
  a_start_latch: assert property (job_start
    |-> write_enable_latch && !deep_power_down)
    else $error("job started without latch");
  a_job_held: assert property (!job_start |-> $stable(job))
    else $error("job changed without start");
  a_chip_unprot: assert property (job_start && job.kind == JOB_CHIP
    |-> block_protect_field == 4'h0) else $error("chip erase protected");
  a_pg_pulse: assert property ($rose(pg_wr) |=> !pg_wr)
    else $error("page write longer than a cycle");
endmodule

bind sf_cmd_if sf_cmd_if_props chk_u (.clk_sys(clk_sys), .nrst(nrst),
  .cs_n(cs_n), .dual_line_zero_oe_n(dual_line_zero_oe_n),
  .dual_line_one_oe_n(dual_line_one_oe_n), .job_start(job_start),
  .job(job), .job_done(job_done), .pg_wr(pg_wr),
  .write_in_progress(write_in_progress),
  .write_enable_latch(write_enable_latch),
  .block_protect_field(block_protect_field),
  .deep_power_down(deep_power_down), .standby(standby));

//--- dv/tb_serial_flash_command_interface.sv
// Self-checking bench for the flash command front end.
// Assumes sf_host_model on the link and a behavioural back end here.
`timescale 1ns/1ns
module tb_serial_flash_command_interface;
  import sf_pkg::*;
  localparam logic [7:0] MFR = 8'hC3;  // Arbitrary value
  localparam logic [15:0] DEV = 16'h7E42;  // Arbitrary value
  localparam logic [7:0] MKD = 8'h24;  // Arbitrary value
  localparam logic [7:0] SIG = 8'h66;  // Arbitrary value
  localparam logic [7:0] OPS[6] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h02};
  localparam int NB[6] = '{32, 32, 32, 8, 8, 40};
  localparam job_e KD[6] = '{JOB_SECTOR, JOB_BLOCK, JOB_BLOCK, JOB_CHIP,
    JOB_CHIP, JOB_PAGE};
  localparam logic [7:0] RD[3] = '{8'h03, 8'h0B, 8'h3B};
  // Erase jobs carry the sector or block base, chip erase zero
  localparam logic [22:0] JA[6] = '{23'h123000, 23'h120000, 23'h120000,
    23'h0, 23'h0, 23'h123456};
  localparam logic [511:0] UID = 512'h9D4E71;  // Arbitrary value
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic job_done = 1'b0;
  logic sclk, cs_n, mosi, line0, line1, zo, zoe_n, oo, ooe_n;
  logic job_start, pg_wr, busy, latch, dpd, stby;
  logic [3:0] bp;
  logic [22:0] arr_addr;
  logic [7:0] arr_rdata;
  job_req_s job, last_job;
  page_byte_s pg_byte, last_pg;
  int n_fail = 0;
  int cmp_count = 0;
  int n_jobs = 0;
  int n_drv = 0;
  always #5 clk_sys = ~clk_sys;
  assign line0 = zoe_n ? mosi : zo;
  assign line1 = ooe_n ? ~oo : oo;
  // Back end array: data is a fixed function of the address
  assign arr_rdata = arr_addr[7:0] ^ 8'h5A;
  sf_cmd_if #(.MFR_ID(MFR), .DEV_ID(DEV), .MAKER_DEV_ID(MKD),
    .SIG_ID(SIG), .UNIQUE_ID(UID))
  dut_u (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
    .dual_line_zero_i(line0), .dual_line_zero_o(zo),
    .dual_line_zero_oe_n(zoe_n), .dual_line_one_o(oo),
    .dual_line_one_oe_n(ooe_n), .arr_addr(arr_addr),
    .arr_rdata(arr_rdata), .job_start(job_start), .job(job),
    .job_done(job_done), .pg_wr(pg_wr), .pg_byte(pg_byte),
    .write_in_progress(busy), .write_enable_latch(latch),
    .block_protect_field(bp), .deep_power_down(dpd), .standby(stby));
  sf_host_model host_u (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .line_zero(line0), .line_one(line1));
  always @(negedge clk_sys) begin
    if (!ooe_n)
      n_drv++;
  end
  always @(posedge clk_sys) begin
    if (job_start) begin
      last_job <= job;
      n_jobs <= n_jobs + 1;
    end
    if (pg_wr)
      last_pg <= pg_byte;
  end
  // Jobs take long enough that a status read sees them busy
  always begin
    @(posedge clk_sys iff job_start);
    repeat (300) @(negedge clk_sys);
    job_done = 1'b1;
    @(negedge clk_sys);
    job_done = 1'b0;
  end
  // ----
  // Compare, poll and closing tasks
  // ----
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic poll_idle();
    int k;
    for (k = 0; k < 20; k++) begin
      host_u.frame(64'h05, 8, 1, 0);
      if (host_u.rx[0][0] === 1'b0)
        break;
    end
    if (k == 20) begin
      n_fail++;
      $display("BAD %0t busy never cleared", $time);
      conclude();
    end
  endtask
  initial begin
    #1000000;
    n_fail++;
    $display("BAD %0t run timed out", $time);
    conclude();
  end
  // ----
  // Test sequence
  // ----
  initial begin
    int n0;
    logic [39:0] h;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({latch, busy, bp, dpd, stby, zoe_n, ooe_n}, 24'h7, "reset");
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      host_u.cpol = m[0];
      host_u.frame(64'h06, 8, 0, 0);
      chk(latch, 1'b1, "latch set");
      host_u.frame(64'h05, 8, 2, 0);
      chk(host_u.rx[1], 8'h02, "status");
      host_u.frame(64'h04, 8, 0, 0);
      chk(latch, 1'b0, "latch clear");
    end
    host_u.frame(64'h00C, 9, 0, 0);
    chk(latch, 1'b0, "partial byte");
    n0 = n_drv;
    host_u.frame(64'hFF, 8, 1, 0);
    chk(24'(n_drv - n0), 24'h0, "unknown opcode");
    $display("test link done");
    host_u.frame(64'h06, 8, 0, 0);
    host_u.frame(64'h0104, 16, 0, 0);
    chk({bp, latch}, 5'h02, "protect write");
    host_u.frame(64'h06, 8, 0, 0);
    n0 = n_jobs;
    host_u.frame(64'h207F0000, 32, 0, 0);
    chk(24'(n_jobs - n0), 24'h0, "protected erase");
    host_u.frame(64'h0100, 16, 0, 0);
    chk(bp, 4'h0, "unprotect");
    $display("test protect done");
    for (int i = 0; i < 6; i++) begin
      h = {OPS[i], 32'h1234569C} >> (40 - NB[i]);
      host_u.frame(64'h06, 8, 0, 0);
      n0 = n_jobs;
      host_u.frame(64'(h), NB[i], 0, 0);
      chk(24'(n_jobs - n0), 24'h1, "job started");
      chk(last_job.kind, KD[i], "job kind");
      chk(last_job.addr, JA[i], "job address");
      if (i == 5)
        chk(last_pg, 16'h569C, "page byte");
      host_u.frame(64'h05, 8, 1, 0);
      chk(host_u.rx[0], 8'h03, "busy status");
      poll_idle();
      chk(latch, 1'b0, "latch after job");
    end
    $display("test jobs done");
    for (int i = 0; i < 3; i++) begin
      h = {RD[i], 32'h0000FE00} >> (i == 0 ? 8 : 0);
      host_u.frame(64'(h), i == 0 ? 32 : 40, 3, i == 2);
      for (int k = 0; k < 3; k++)
        chk(host_u.rx[k], 8'(8'hFE + k) ^ 8'h5A, "array data");
    end
    $display("test reads done");
    host_u.frame(64'h9F, 8, 3, 0);
    chk({host_u.rx[0], host_u.rx[1], host_u.rx[2]}, {MFR, DEV}, "id");
    host_u.frame(64'h90000000, 32, 2, 0);
    chk({host_u.rx[0], host_u.rx[1]}, {MFR, MKD}, "maker device");
    host_u.frame(64'h2B, 8, 1, 0);
    chk(host_u.rx[0], 8'h01, "security");
    host_u.frame(64'h06, 8, 0, 0);
    host_u.frame(64'h2F, 8, 0, 0);
    host_u.frame(64'h2B, 8, 1, 0);
    chk(host_u.rx[0], 8'h03, "security lock");
    host_u.frame(64'hE1, 8, 0, 0);
    host_u.frame(64'h03000001, 32, 2, 0);
    chk({host_u.rx[0], host_u.rx[1]}, {UID[15:8], UID[23:16]}, "area");
    host_u.frame(64'hE2, 8, 0, 0);
    host_u.frame(64'h03000001, 32, 1, 0);
    chk(host_u.rx[0], 8'h01 ^ 8'h5A, "area exit");
    $display("test ident done");
    host_u.frame(64'hB9, 8, 0, 0);
    host_u.frame(64'h04, 8, 0, 0);
    chk({dpd, latch}, 2'h3, "power down");
    host_u.frame(64'hAB000000, 32, 1, 0);
    chk({dpd, host_u.rx[0]}, {1'b0, SIG}, "signature");
    $display("test power done");
    conclude();
  end
endmodule
